// [hdl/pmic_irq_pkg.sv]
// constants for the interrupt flag and mask block
// Operation
// RULE1 - buck-boost fault change sets flag two bit 7
// RULE2 - harvester comparator change sets bit 6
// RULE3 - system-battery limit change sets bit 5
// RULE4 - charger system-limit change sets bit 4
// RULE5 - charger step change sets bit 3
// RULE6 - first thermal buck change sets bit 2
// RULE7 - second thermal buck change sets bit 1
// RULE8 - third thermal buck change sets bit 0
// RULE9 - battery-good change sets bit 7 at 0x09
// RULE10 - regulation-done change sets bit 6 at 0x09
// RULE11 - boost fault sets bit 5; bit 4 unused
// RULE12 - crc-failed write discarded, sets bit 3
// RULE13 - 100ms bus inactivity in transaction sets bit 2
// RULE14 - bits 1,0 read-only haptic and converter summaries
// RULE15 - mask bit 7 gates thermal flag, 1 passes
// RULE16 - mask bit 4 gates overvoltage flag, 1 passes
// RULE17 - mask bits 6,5,3 gate charger, limit, valid
// RULE18 - masked flags recorded; unmasked set flags assert irq
// RULE19 - thermal status field change sets flag zero bit 7
`default_nettype none

package pmic_irq_pkg;
	localparam logic [7:0] FLAGS_ZERO_OFFSET = 8'h06;
	localparam logic [7:0] FLAGS_TWO_OFFSET = 8'h08;
	localparam logic [7:0] FLAGS_THREE_OFFSET = 8'h09;
	localparam logic [7:0] MASK_ZERO_OFFSET = 8'h0A;

	// flag zero and mask zero bit positions
	localparam int THERMAL_STATUS_BIT = 7;
	localparam int CHARGER_STATUS_BIT = 6;
	localparam int CURRENT_LIMIT_BIT = 5;
	localparam int INPUT_OVERVOLTAGE_BIT = 4;
	localparam int INPUT_VALID_BIT = 3;

	// flag three bit positions
	localparam int BATTERY_GOOD_BIT = 7;
	localparam int BATTERY_REGULATION_DONE_BIT = 6;
	localparam int BOOST_FAULT_BIT = 5;
	localparam int BUS_CRC_FAIL_BIT = 3;
	localparam int BUS_TIMEOUT_BIT = 2;
	localparam int HAPTIC_SUMMARY_BIT = 1;
	localparam int CONVERTER_SUMMARY_BIT = 0;

	// bits that exist and may be cleared by writing one
	localparam logic [7:0] FLAGS_ZERO_USED = 8'hF8;
	localparam logic [7:0] FLAGS_THREE_CLEARABLE = 8'hEC;

	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASK_ZERO_RESET = 8'h00;

	localparam int CLOCK_HZ = 20_000_000;
	localparam int BUS_TIMEOUT_MS = 100;
	localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * (CLOCK_HZ / 1000);
endpackage : pmic_irq_pkg

`default_nettype wire

// [hdl/pmic_interrupt_flags_masks.sv]
// interrupt flags, mask zero and bus watchdog of the power manager
`default_nettype none

module pmic_interrupt_flags_masks #(
	parameter int BUS_TIMEOUT_CYCLES = pmic_irq_pkg::BUS_TIMEOUT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	// register port from the serial interface engine
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_crc_ok,
	output logic [7:0] reg_rdata,
	// transaction tracking from the serial interface engine
	input wire logic bus_start,
	input wire logic bus_stop,
	input wire logic bus_activity,
	output logic bus_timeout_abort,
	// summaries from the haptic and converter sub-blocks, same clock
	input wire logic haptic_pending,
	input wire logic converter_pending,
	// analog status levels, asynchronous
	input wire logic [2:0] thermal_status_field,
	input wire logic [2:0] charger_status_field,
	input wire logic current_limit_status,
	input wire logic input_overvoltage_status,
	input wire logic input_valid_status,
	input wire logic buckboost_fault_status,
	input wire logic harvester_compare_status,
	input wire logic system_battery_limit_status,
	input wire logic charger_system_limit_status,
	input wire logic charge_step_status,
	input wire logic thermal_buck_one_status,
	input wire logic thermal_buck_two_status,
	input wire logic thermal_buck_three_status,
	input wire logic battery_good_status,
	input wire logic battery_regulation_done_status,
	input wire logic boost_fault_status,
	output logic irq
);
	import pmic_irq_pkg::*;

	localparam int STATUS_W = 20;

	if (BUS_TIMEOUT_CYCLES < 2) begin : g_bad_timeout
		$error("BUS_TIMEOUT_CYCLES must be at least 2");
	end

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] f0,
			input logic [7:0] f2, input logic [7:0] f3, input logic [7:0] m0);
		case (addr)
			FLAGS_ZERO_OFFSET: read_mux = f0;
			FLAGS_TWO_OFFSET: read_mux = f2;
			FLAGS_THREE_OFFSET: read_mux = f3;
			MASK_ZERO_OFFSET: read_mux = m0;
			default: read_mux = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] write_ones(input logic hit_wr, input logic [7:0] addr,
			input logic [7:0] target, input logic [7:0] data);
		write_ones = (hit_wr && addr == target) ? data : 8'h00;
	endfunction

	// status synchronisers and change detection
	logic [STATUS_W-1:0] status_raw;
	logic [STATUS_W-1:0] sync1_r, sync1_nxt;
	logic [STATUS_W-1:0] sync2_r, sync2_nxt;
	logic [STATUS_W-1:0] prev_r, prev_nxt;
	logic [2:0] warm_r, warm_nxt;
	logic [STATUS_W-1:0] changed;

	assign status_raw = {thermal_status_field, charger_status_field, current_limit_status,
		input_overvoltage_status, input_valid_status, buckboost_fault_status,
		harvester_compare_status, system_battery_limit_status, charger_system_limit_status,
		charge_step_status, thermal_buck_one_status, thermal_buck_two_status,
		thermal_buck_three_status, battery_good_status, battery_regulation_done_status,
		boost_fault_status};

	always_comb begin
		sync1_nxt = status_raw;
		sync2_nxt = sync1_r;
		prev_nxt = sync2_r;
		// three edges fill sync and prev, so a level already up at reset is no change
		warm_nxt = {warm_r[1:0], 1'b1};
		changed = warm_r[2] ? (sync2_r ^ prev_r) : '0;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
			warm_r <= 3'b000;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
			warm_r <= warm_nxt;
		end
	end

	// bus watchdog
	logic in_txn_r, in_txn_nxt;
	logic [31:0] idle_cnt_r, idle_cnt_nxt;
	logic abort_r, abort_nxt;
	logic timeout_hit;

	always_comb begin
		in_txn_nxt = in_txn_r;
		idle_cnt_nxt = idle_cnt_r;
		abort_nxt = 1'b0;
		timeout_hit = 1'b0;
		if (bus_start) begin
			in_txn_nxt = 1'b1;
			idle_cnt_nxt = '0;
		end else if (bus_stop) begin
			in_txn_nxt = 1'b0;
			idle_cnt_nxt = '0;
		end else if (in_txn_r) begin
			if (bus_activity) begin
				idle_cnt_nxt = '0;
			end else if (idle_cnt_r == 32'(BUS_TIMEOUT_CYCLES - 1)) begin
				// give up the transaction so a stuck master cannot hold the bus
				timeout_hit = 1'b1; // [RULE13]
				abort_nxt = 1'b1;
				in_txn_nxt = 1'b0;
				idle_cnt_nxt = '0;
			end else begin
				idle_cnt_nxt = idle_cnt_r + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			in_txn_r <= 1'b0;
			idle_cnt_r <= '0;
			abort_r <= 1'b0;
		end else begin
			in_txn_r <= in_txn_nxt;
			idle_cnt_r <= idle_cnt_nxt;
			abort_r <= abort_nxt;
		end
	end

	// flag, mask and read-back registers
	logic [7:0] flags_zero_r, flags_zero_nxt;
	logic [7:0] flags_two_r, flags_two_nxt;
	logic [7:0] flags_three_r, flags_three_nxt;
	logic [7:0] mask_zero_r, mask_zero_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic wr_ok;
	logic crc_fail;
	logic [7:0] set_zero, set_two, set_three;
	logic [7:0] clr_zero, clr_two, clr_three;

	always_comb begin
		wr_ok = reg_wr && reg_crc_ok;
		crc_fail = reg_wr && !reg_crc_ok; // [RULE12]

		set_zero = 8'h00;
		set_zero[THERMAL_STATUS_BIT] = |changed[19:17]; // [RULE19]
		set_zero[CHARGER_STATUS_BIT] = |changed[16:14];
		set_zero[CURRENT_LIMIT_BIT] = changed[13];
		set_zero[INPUT_OVERVOLTAGE_BIT] = changed[12];
		set_zero[INPUT_VALID_BIT] = changed[11];

		// bit order of the status vector matches the register bit order
		set_two = changed[10:3]; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]

		set_three = 8'h00;
		set_three[BATTERY_GOOD_BIT] = changed[2]; // [RULE9]
		set_three[BATTERY_REGULATION_DONE_BIT] = changed[1]; // [RULE10]
		set_three[BOOST_FAULT_BIT] = changed[0]; // [RULE11]
		set_three[BUS_CRC_FAIL_BIT] = crc_fail; // [RULE12]
		set_three[BUS_TIMEOUT_BIT] = timeout_hit; // [RULE13]

		// failed-crc writes never reach here, so the register keeps its value
		clr_zero = write_ones(wr_ok, reg_addr, FLAGS_ZERO_OFFSET, reg_wdata); // [RULE12]
		clr_two = write_ones(wr_ok, reg_addr, FLAGS_TWO_OFFSET, reg_wdata);
		clr_three = write_ones(wr_ok, reg_addr, FLAGS_THREE_OFFSET, reg_wdata);

		// set wins over a clear landing in the same cycle
		flags_zero_nxt = ((flags_zero_r & ~clr_zero) | set_zero) & FLAGS_ZERO_USED;
		flags_two_nxt = (flags_two_r & ~clr_two) | set_two;
		flags_three_nxt = ((flags_three_r & ~clr_three) | set_three) & FLAGS_THREE_CLEARABLE;
		// summaries follow the sub-blocks and ignore writes
		flags_three_nxt[HAPTIC_SUMMARY_BIT] = haptic_pending; // [RULE14]
		flags_three_nxt[CONVERTER_SUMMARY_BIT] = converter_pending; // [RULE14]

		mask_zero_nxt = mask_zero_r;
		if (wr_ok && reg_addr == MASK_ZERO_OFFSET) begin
			mask_zero_nxt = reg_wdata;
		end

		rdata_nxt = rdata_r;
		if (reg_rd) begin
			rdata_nxt = read_mux(reg_addr, flags_zero_r, flags_two_r, flags_three_r,
				mask_zero_r);
		end

		// mask only gates the output; the flag itself is still recorded
		irq_nxt = |(flags_zero_r & mask_zero_r & FLAGS_ZERO_USED) // [RULE15] [RULE16] [RULE17] [RULE18]
			| (|flags_two_r) | (|flags_three_r); // [RULE18]
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_zero_r <= FLAGS_RESET;
			flags_two_r <= FLAGS_RESET;
			flags_three_r <= FLAGS_RESET;
			mask_zero_r <= MASK_ZERO_RESET;
			rdata_r <= 8'h00;
			irq_r <= 1'b0;
		end else begin
			flags_zero_r <= flags_zero_nxt;
			flags_two_r <= flags_two_nxt;
			flags_three_r <= flags_three_nxt;
			mask_zero_r <= mask_zero_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign bus_timeout_abort = abort_r;
	assign irq = irq_r;
endmodule // pmic_interrupt_flags_masks

`default_nettype wire

// [test/pmic_irq_props.sv]
// port assertions for the interrupt flag and mask block
`default_nettype none

module pmic_irq_props #(
	parameter int BUS_TIMEOUT_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_crc_ok,
	input wire logic [7:0] reg_rdata,
	input wire logic bus_start,
	input wire logic bus_stop,
	input wire logic bus_timeout_abort,
	input wire logic haptic_pending,
	input wire logic converter_pending,
	input wire logic buckboost_fault_status,
	input wire logic irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// quiet windows assume a timeout of at least eight cycles
	AST_SUMMARY: assert property (reg_rd && reg_addr == 8'h09 |=>
		reg_rdata[1:0] == $past({haptic_pending, converter_pending}, 2)) else $error("summary");
	AST_UNUSED_BIT: assert property (reg_rd && reg_addr == 8'h09 |=> !reg_rdata[4])
		else $error("bit 4 set");
	logic [7:0] mask_shadow_r;
	// reference copy of mask zero, moved only by writes whose crc passed
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask_shadow_r <= 8'h00;
		end else if (reg_wr && reg_crc_ok && reg_addr == 8'h0a) begin
			mask_shadow_r <= reg_wdata;
		end
	end
	AST_MASK_RW: assert property (reg_rd && reg_addr == 8'h0a |=>
		reg_rdata == $past(mask_shadow_r))
		else $error("mask readback");
	AST_CRC_IRQ: assert property (reg_wr && !reg_crc_ok |-> ##2 irq) else $error("crc irq");
	AST_STATUS_IRQ: assert property ($changed(buckboost_fault_status) |-> ##[3:6] irq)
		else $error("status irq");
	AST_WDOG_QUIET: assert property (bus_start |=> !bus_timeout_abort [*8]) else $error("early");
	AST_IDLE_QUIET: assert property (bus_stop |=> !bus_timeout_abort [*8]) else $error("idle");
	AST_ABORT_PULSE: assert property (bus_timeout_abort |=> !bus_timeout_abort && irq)
		else $error("abort pulse");
endmodule // pmic_irq_props

bind pmic_interrupt_flags_masks pmic_irq_props #(.BUS_TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)) props_u (
	.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_crc_ok(reg_crc_ok), .reg_rdata(reg_rdata), .bus_start(bus_start),
	.bus_stop(bus_stop), .bus_timeout_abort(bus_timeout_abort), .haptic_pending(haptic_pending),
	.converter_pending(converter_pending), .buckboost_fault_status(buckboost_fault_status),
	.irq(irq));

`default_nettype wire

// [test/pmic_host_model.sv]
// host side of the register port, single byte transfers
`default_nettype none

module pmic_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_crc_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_crc_ok = 1'b0;
	end
	// strobes drop low; address, data and crc lines go inverted so a stale value never looks live
	task automatic release_bus();
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
		reg_crc_ok = ~reg_crc_ok;
	endtask
	task automatic write(input logic [7:0] a, input logic [7:0] d, input logic ok);
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		reg_crc_ok = ok;
		release_bus();
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		release_bus();
		d = reg_rdata;
	endtask
endmodule // pmic_host_model

`default_nettype wire

// [test/pmic_interrupt_flags_masks_tb.sv]
// self-checking bench for the interrupt flag and mask block
`default_nettype none

module pmic_interrupt_flags_masks_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pmic_irq_pkg::*;
	localparam int TMO = 20;
	logic sys_clk = 0, rst = 1, bus_start = 0, bus_stop = 0, bus_activity = 0, hap = 0, conv = 0;
	logic [7:0] s2 = 0;
	logic [2:0] s3 = 0;
	logic [4:0] s0 = 0;
	logic reg_wr, reg_rd, reg_crc_ok, abort, irq;
	logic [7:0] reg_addr, reg_wdata, rdata, d;
	int fail_count = 0, check_count = 0, cyc = 0;
	pmic_host_model host_u (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_crc_ok(reg_crc_ok));
	pmic_interrupt_flags_masks #(.BUS_TIMEOUT_CYCLES(TMO)) dut_u (.sys_clk(sys_clk), .rst(rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_crc_ok(reg_crc_ok), .reg_rdata(rdata), .bus_start(bus_start), .bus_stop(bus_stop),
		.bus_activity(bus_activity), .bus_timeout_abort(abort), .haptic_pending(hap),
		.converter_pending(conv), .thermal_status_field({2'b00, s0[4]}),
		.charger_status_field({2'b00, s0[3]}), .current_limit_status(s0[2]),
		.input_overvoltage_status(s0[1]), .input_valid_status(s0[0]),
		.buckboost_fault_status(s2[7]), .harvester_compare_status(s2[6]),
		.system_battery_limit_status(s2[5]), .charger_system_limit_status(s2[4]),
		.charge_step_status(s2[3]), .thermal_buck_one_status(s2[2]),
		.thermal_buck_two_status(s2[1]), .thermal_buck_three_status(s2[0]),
		.battery_good_status(s3[2]), .battery_regulation_done_status(s3[1]),
		.boost_fault_status(s3[0]), .irq(irq));
	initial forever #25 sys_clk = ~sys_clk;
	task automatic test_done();
		if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		host_u.read(a, d);
		chk(d, exp);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		tick(3);
		rst = 0;
		tick(4);
		for (int i = 0; i < 5; i++) rd_chk(8'h06 + 8'(i), 8'h00);
		host_u.write(8'h0a, 8'ha5, 1);
		rd_chk(8'h0a, 8'ha5);
		host_u.write(8'h0a, 8'h5a, 0);
		rd_chk(8'h0a, 8'ha5);
		rd_chk(8'h09, 8'h08);
		chk({7'h00, irq}, 8'h01);
		host_u.write(8'h09, 8'h08, 1);
		host_u.write(8'h0a, 8'h00, 1);
		for (int i = 0; i < 8; i++) begin
			s2[i] = ~s2[i];
			tick(6);
			rd_chk(8'h08, 8'h01 << i);
			host_u.write(8'h08, 8'h01 << i, 1);
		end
		for (int i = 0; i < 3; i++) begin
			s3[i] = ~s3[i];
			tick(6);
			rd_chk(8'h09, 8'h20 << i);
			host_u.write(8'h09, 8'h20 << i, 1);
		end
		for (int i = 0; i < 5; i++) begin
			s0[i] = ~s0[i];
			tick(6);
			rd_chk(8'h06, 8'h08 << i);
			chk({7'h00, irq}, 8'h00);
			host_u.write(8'h0a, 8'h08 << i, 1);
			tick(1);
			chk({7'h00, irq}, 8'h01);
			host_u.write(8'h06, 8'h08 << i, 1);
			tick(1);
			chk({7'h00, irq}, 8'h00);
		end
		hap = 1;
		tick(2);
		host_u.write(8'h09, 8'hff, 1);
		rd_chk(8'h09, 8'h02);
		hap = 0;
		conv = 1;
		tick(2);
		rd_chk(8'h09, 8'h01);
		conv = 0;
		bus_start = 1;
		tick(1);
		bus_start = 0;
		repeat (4) begin
			tick(TMO - 2);
			bus_activity = 1;
			tick(1);
			bus_activity = 0;
		end
		bus_stop = 1;
		tick(1);
		bus_stop = 0;
		tick(TMO + 5);
		rd_chk(8'h09, 8'h00);
		bus_start = 1;
		tick(1);
		bus_start = 0;
		tick(TMO);
		chk({7'h00, abort}, 8'h01);
		tick(1);
		chk({6'h00, abort, irq}, 8'h01);
		tick(2);
		rd_chk(8'h09, 8'h04);
		// statuses all stand high now; after reset they are the baseline
		rst = 1;
		tick(2);
		rst = 0;
		tick(6);
		for (int i = 0; i < 5; i++) rd_chk(8'h06 + 8'(i), 8'h00);
		chk({7'h00, irq}, 8'h00);
		test_done();
	end
endmodule // pmic_interrupt_flags_masks_tb

`default_nettype wire
